// *** logic/fpm_fan_mux.sv ***
// fan drive behaviour mux: duty sources, thresholds, spin-up, waveform and shared pin
`timescale 1ns/100ps
`default_nettype none

// Contract
// - each output has a 3-bit behaviour select in config bits 7:5
// - select 111 makes duty register writable and drives output directly
// - duty registers are 8 bits spanning 0 to 100 percent
// - duty registers reset to ff, full duty
// - reading a duty register returns the applied duty in every mode
// - codes 000, 001, 010 follow remote 1, local, remote 2 channel
// - code 101 takes the faster of local and remote 2
// - code 110 takes the fastest of all three channels
// - code 011 is full speed and the reset value; 100 disables
// - config three bit 0 picks alert output or drive 2 on shared pin
// - each channel has an 8-bit signed turn-on threshold, 1 degree per step
// - above threshold the fan turns on at its minimum duty
// - fan turns off only below threshold minus off hysteresis
// - on turn-on the fan spins up until two tach rising edges
// - hold-min bits keep outputs at minimum duty below threshold
// - polarity bit 4: 0 means high at full duty, 1 means low
// - hold-min bit 7 is output 3, bit 6 output 2, bit 5 output 1
module fpm_fan_mux #(
	parameter int TACH_EDGES = fpm_pkg::TACH_EDGES_DEF
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       nrst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	// temperatures and computed speeds, same clock
	input  wire logic [7:0] temp_remote1,
	input  wire logic [7:0] temp_local,
	input  wire logic [7:0] temp_remote2,
	input  wire logic [7:0] speed_remote1,
	input  wire logic [7:0] speed_local,
	input  wire logic [7:0] speed_remote2,
	// tach pins, asynchronous
	input  wire logic       tach_1,
	input  wire logic       tach_2,
	input  wire logic       tach_3,
	// alert request from status logic
	input  wire logic       alert_req,
	// drive pins
	output var  logic       fan_drive_1,
	output var  logic       fan_drive_3,
	output var  logic       shared_pin_out,
	output var  logic       shared_pin_oe_n
);

	// ========================================
	// parameter check
	generate
		if (TACH_EDGES < 1 || TACH_EDGES > 3) begin : g_bad_edges
			$error("TACH_EDGES must be 1 to 3");
		end
	endgenerate

	localparam logic [1:0] EDGES_DONE = 2'(TACH_EDGES);

	// ========================================
	// state
	typedef struct packed {
		logic [2:0][7:0] duty;
		logic [2:0][7:0] cfg;
		logic [2:0][7:0] min_duty;
		logic [2:0][7:0] tmin;
		logic [7:0]      acous;
		logic [7:0]      conf3;
		logic [7:0]      hyst;
		logic [2:0]      chan_on;
		logic [2:0]      fan_on;
		logic [2:0]      spin;
		logic [2:0][1:0] edges;
		logic [2:0]      tach_s1;
		logic [2:0]      tach_s2;
		logic [2:0]      tach_s3;
		logic [7:0]      cnt;
		logic [2:0]      drive;
		logic            share_out;
		logic            share_oe_n;
		logic [7:0]      rdata;
	} fpm_state_t;

	fpm_state_t      s_q;
	fpm_state_t      s_d;
	logic [2:0][7:0] temp;
	logic [2:0][7:0] speed;
	logic [2:0]      tach_pin;
	logic [2:0][7:0] applied;
	logic [2:0]      is_auto;
	logic [2:0]      want_on;
	logic [2:0]      rise;

	assign temp     = {temp_remote2, temp_local, temp_remote1};
	assign speed    = {speed_remote2, speed_local, speed_remote1};
	assign tach_pin = {tach_3, tach_2, tach_1};

	// ========================================
	// helpers
	function automatic logic signed [9:0] sx(input logic [7:0] v);
		return signed'({{2{v[7]}}, v});
	endfunction

	function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
		return (a > b) ? a : b;
	endfunction

	// speed one channel asks of one output; below the turn-off point either 0 or held minimum
	function automatic logic [7:0] chan_speed(input logic on, input logic hold,
			input logic [7:0] mind, input logic [7:0] sp);
		if (on)
			return max8(mind, sp);
		return hold ? mind : fpm_pkg::DUTY_ZERO;
	endfunction

	// ========================================
	// next state
	always_comb begin
		s_d = s_q;
		applied = '0;
		is_auto = '0;
		want_on = '0;
		rise = '0;

		// tach synchronisers, edge seen after the second stage
		s_d.tach_s1 = tach_pin;
		s_d.tach_s2 = s_q.tach_s1;
		s_d.tach_s3 = s_q.tach_s2;
		rise = s_q.tach_s2 & ~s_q.tach_s3;

		// per channel turn-on with hysteresis; the band keeps the last state
		for (int c = 0; c < 3; c++) begin
			if (sx(temp[c]) > sx(s_q.tmin[c]))
				s_d.chan_on[c] = 1'b1;
			else if (sx(temp[c]) < sx(s_q.tmin[c]) - sx(s_q.hyst))
				s_d.chan_on[c] = 1'b0;
		end

		// behaviour mux per output
		for (int n = 0; n < 3; n++) begin
			logic [7:0] r1;
			logic [7:0] lo;
			logic [7:0] r2;
			logic       hold;
			r1 = '0;
			lo = '0;
			r2 = '0;
			hold = s_q.acous[fpm_pkg::HOLD_MIN_LO + n];
			r1 = chan_speed(s_q.chan_on[0], hold, s_q.min_duty[n], speed[0]);
			lo = chan_speed(s_q.chan_on[1], hold, s_q.min_duty[n], speed[1]);
			r2 = chan_speed(s_q.chan_on[2], hold, s_q.min_duty[n], speed[2]);
			unique case (s_q.cfg[n][fpm_pkg::SEL_HI:fpm_pkg::SEL_LO])
				fpm_pkg::SEL_REMOTE1: begin
					applied[n] = r1;
					is_auto[n] = 1'b1;
					want_on[n] = s_q.chan_on[0];
				end
				fpm_pkg::SEL_LOCAL: begin
					applied[n] = lo;
					is_auto[n] = 1'b1;
					want_on[n] = s_q.chan_on[1];
				end
				fpm_pkg::SEL_REMOTE2: begin
					applied[n] = r2;
					is_auto[n] = 1'b1;
					want_on[n] = s_q.chan_on[2];
				end
				fpm_pkg::SEL_MAX_LR2: begin
					applied[n] = max8(lo, r2);
					is_auto[n] = 1'b1;
					want_on[n] = s_q.chan_on[1] | s_q.chan_on[2];
				end
				fpm_pkg::SEL_MAX_ALL: begin
					applied[n] = max8(r1, max8(lo, r2));
					is_auto[n] = 1'b1;
					want_on[n] = |s_q.chan_on;
				end
				fpm_pkg::SEL_FULL: applied[n] = fpm_pkg::DUTY_FULL;
				fpm_pkg::SEL_OFF: applied[n] = fpm_pkg::DUTY_ZERO;
				fpm_pkg::SEL_MANUAL: applied[n] = s_q.duty[n];
			endcase

			// spin-up runs full until enough tach edges, then hands over to the source
			if (!is_auto[n]) begin
				s_d.spin[n] = 1'b0;
			end else if (want_on[n] && !s_q.fan_on[n]) begin
				s_d.spin[n] = 1'b1;
				s_d.edges[n] = 2'h0;
			end else if (s_q.spin[n] && rise[n]) begin
				s_d.edges[n] = s_q.edges[n] + 2'h1;
				if (s_q.edges[n] + 2'h1 == EDGES_DONE)
					s_d.spin[n] = 1'b0;
			end
			if (!want_on[n])
				s_d.spin[n] = 1'b0;
			s_d.fan_on[n] = is_auto[n] & want_on[n];
			if (is_auto[n] && s_q.spin[n])
				applied[n] = fpm_pkg::DUTY_FULL;

			// register tracks the applied duty; only manual mode lets software in
			s_d.duty[n] = applied[n];
		end

		// waveform: period of 255 counts, so ff is never inactive
		s_d.cnt = (s_q.cnt == fpm_pkg::PWM_TOP) ? 8'h00 : s_q.cnt + 8'h01;
		for (int n = 0; n < 3; n++)
			s_d.drive[n] = (s_q.cnt < s_q.duty[n]) ^ s_q.cfg[n][fpm_pkg::POL_BIT];

		// shared pin: alert is open drain, drive 2 is push-pull
		if (s_q.conf3[fpm_pkg::SHARE_BIT]) begin
			s_d.share_out = 1'b0;
			s_d.share_oe_n = ~alert_req;
		end else begin
			s_d.share_out = s_d.drive[1];
			s_d.share_oe_n = 1'b0;
		end

		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				fpm_pkg::ADDR_DUTY1,
				fpm_pkg::ADDR_DUTY2,
				fpm_pkg::ADDR_DUTY3: begin
					for (int n = 0; n < 3; n++)
						if (reg_addr == fpm_pkg::ADDR_DUTY1 + 8'(n)
								&& s_q.cfg[n][fpm_pkg::SEL_HI:fpm_pkg::SEL_LO] == fpm_pkg::SEL_MANUAL)
							s_d.duty[n] = reg_wdata;
				end
				fpm_pkg::ADDR_CFG1: s_d.cfg[0] = reg_wdata;
				fpm_pkg::ADDR_CFG2: s_d.cfg[1] = reg_wdata;
				fpm_pkg::ADDR_CFG3D: s_d.cfg[2] = reg_wdata;
				fpm_pkg::ADDR_ACOUS: s_d.acous = reg_wdata;
				fpm_pkg::ADDR_FLOOR1: s_d.min_duty[0] = reg_wdata;
				fpm_pkg::ADDR_FLOOR2: s_d.min_duty[1] = reg_wdata;
				fpm_pkg::ADDR_FLOOR3: s_d.min_duty[2] = reg_wdata;
				fpm_pkg::ADDR_TMIN1: s_d.tmin[0] = reg_wdata;
				fpm_pkg::ADDR_TMIN2: s_d.tmin[1] = reg_wdata;
				fpm_pkg::ADDR_TMIN3: s_d.tmin[2] = reg_wdata;
				fpm_pkg::ADDR_HYST: s_d.hyst = reg_wdata;
				fpm_pkg::ADDR_CONF3: s_d.conf3 = reg_wdata;
				default: ;
			endcase
		end

		// register reads, data stand for the following cycle only
		s_d.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				fpm_pkg::ADDR_DUTY1: s_d.rdata = s_q.duty[0];
				fpm_pkg::ADDR_DUTY2: s_d.rdata = s_q.duty[1];
				fpm_pkg::ADDR_DUTY3: s_d.rdata = s_q.duty[2];
				fpm_pkg::ADDR_CFG1: s_d.rdata = s_q.cfg[0];
				fpm_pkg::ADDR_CFG2: s_d.rdata = s_q.cfg[1];
				fpm_pkg::ADDR_CFG3D: s_d.rdata = s_q.cfg[2];
				fpm_pkg::ADDR_ACOUS: s_d.rdata = s_q.acous;
				fpm_pkg::ADDR_FLOOR1: s_d.rdata = s_q.min_duty[0];
				fpm_pkg::ADDR_FLOOR2: s_d.rdata = s_q.min_duty[1];
				fpm_pkg::ADDR_FLOOR3: s_d.rdata = s_q.min_duty[2];
				fpm_pkg::ADDR_TMIN1: s_d.rdata = s_q.tmin[0];
				fpm_pkg::ADDR_TMIN2: s_d.rdata = s_q.tmin[1];
				fpm_pkg::ADDR_TMIN3: s_d.rdata = s_q.tmin[2];
				fpm_pkg::ADDR_HYST: s_d.rdata = s_q.hyst;
				fpm_pkg::ADDR_CONF3: s_d.rdata = s_q.conf3;
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// ========================================
	// registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.duty <= {3{fpm_pkg::DUTY_RST}};
			s_q.cfg <= {3{fpm_pkg::CFG_RST}};
			s_q.min_duty <= {3{fpm_pkg::MIN_RST}};
			s_q.tmin <= {3{fpm_pkg::TMIN_RST}};
			s_q.acous <= fpm_pkg::ACOUS_RST;
			s_q.conf3 <= fpm_pkg::CONF3_RST;
			s_q.hyst <= fpm_pkg::HYST_RST;
			s_q.rdata <= fpm_pkg::RDATA_RST;
			s_q.drive <= 3'h7;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata       = s_q.rdata;
	assign fan_drive_1     = s_q.drive[0];
	assign fan_drive_3     = s_q.drive[2];
	assign shared_pin_out  = s_q.share_out;
	assign shared_pin_oe_n = s_q.share_oe_n;

	// ========================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// behaviour field of each output, shared by the checks below
	logic [2:0][2:0] sel_mode;
	for (genvar g = 0; g < 3; g++) begin : g_sel
		assign sel_mode[g] = s_q.cfg[g][fpm_pkg::SEL_HI:fpm_pkg::SEL_LO];
	end

	manual_write_a: assert property (reg_wr && reg_addr == fpm_pkg::ADDR_DUTY1
		&& sel_mode[0] == fpm_pkg::SEL_MANUAL |=> s_q.duty[0] == $past(reg_wdata))
		else $error("manual duty write not taken");
	full_speed_a: assert property (sel_mode[1] == fpm_pkg::SEL_FULL
		|=> s_q.duty[1] == fpm_pkg::DUTY_FULL)
		else $error("full speed not applied");
	disable_out_a: assert property (sel_mode[2] == fpm_pkg::SEL_OFF
		|=> s_q.duty[2] == fpm_pkg::DUTY_ZERO)
		else $error("disabled output not at zero");
	duty_read_a: assert property (reg_rd && reg_addr == fpm_pkg::ADDR_DUTY2
		|=> reg_rdata == $past(s_q.duty[1]))
		else $error("duty readback wrong");
	rdata_idle_a: assert property (!reg_rd
		|=> reg_rdata == fpm_pkg::RDATA_RST)
		else $error("read data not cleared");
	// polarity may flip right after the first edge, so the second edge looks at what stood then
	wave_full_a: assert property (s_q.duty[0] == fpm_pkg::DUTY_FULL && !s_q.cfg[0][fpm_pkg::POL_BIT]
		|=> fan_drive_1 ##1 (fan_drive_1 || $past(s_q.duty[0]) != fpm_pkg::DUTY_FULL
		|| $past(s_q.cfg[0][fpm_pkg::POL_BIT])))
		else $error("full duty not constant high");
	wave_zero_a: assert property (s_q.duty[0] == fpm_pkg::DUTY_ZERO && !s_q.cfg[0][fpm_pkg::POL_BIT]
		|=> !fan_drive_1)
		else $error("zero duty not constant low");
	wave_pol_a: assert property (s_q.duty[2] == fpm_pkg::DUTY_ZERO && s_q.cfg[2][fpm_pkg::POL_BIT]
		|=> fan_drive_3)
		else $error("inverted zero duty not high");
	share_pin_a: assert property (s_q.conf3[fpm_pkg::SHARE_BIT] |=> !shared_pin_out
		&& shared_pin_oe_n == !$past(alert_req))
		else $error("shared pin alert mode wrong");
	share_drive_a: assert property (!s_q.conf3[fpm_pkg::SHARE_BIT]
		|=> !shared_pin_oe_n && shared_pin_out == s_q.drive[1])
		else $error("shared pin drive mode wrong");
	turn_on_a: assert property (sx(temp_remote1) > sx(s_q.tmin[0])
		|=> s_q.chan_on[0])
		else $error("channel did not turn on");
	hyst_band_a: assert property (s_q.chan_on[0]
		&& sx(temp_remote1) >= sx(s_q.tmin[0]) - sx(s_q.hyst) |=> s_q.chan_on[0])
		else $error("channel turned off inside hysteresis");
	turn_off_a: assert property (sx(temp_local) < sx(s_q.tmin[1]) - sx(s_q.hyst)
		|=> !s_q.chan_on[1])
		else $error("channel did not turn off");
	spin_start_a: assert property (is_auto[0] && want_on[0] && !s_q.fan_on[0]
		|=> s_q.spin[0])
		else $error("spin-up not started");
	spin_full_a: assert property (s_q.spin[0] && is_auto[0] && want_on[0]
		|=> s_q.duty[0] == fpm_pkg::DUTY_FULL)
		else $error("spin-up not at full duty");
	hold_min_a: assert property (sel_mode[0] == fpm_pkg::SEL_LOCAL && !s_q.chan_on[1]
		&& s_q.acous[fpm_pkg::HOLD_MIN_LO] && !s_q.spin[0] |=> s_q.duty[0] == $past(s_q.min_duty[0]))
		else $error("minimum duty not held");
	hold_off_a: assert property (sel_mode[0] == fpm_pkg::SEL_LOCAL && !s_q.chan_on[1]
		&& !s_q.acous[fpm_pkg::HOLD_MIN_LO] && !s_q.spin[0] |=> s_q.duty[0] == fpm_pkg::DUTY_ZERO)
		else $error("output not off below turn-off point");
	auto_ignore_a: assert property (reg_wr && reg_addr == fpm_pkg::ADDR_DUTY1
		&& sel_mode[0] == fpm_pkg::SEL_FULL |=> s_q.duty[0] == fpm_pkg::DUTY_FULL)
		else $error("duty write not ignored");
	local_src_a: assert property (sel_mode[0] == fpm_pkg::SEL_LOCAL && s_q.chan_on[1]
		|=> s_q.duty[0] >= $past(speed_local) && s_q.duty[0] >= $past(s_q.min_duty[0]))
		else $error("local channel speed not followed");
	max_lr2_a: assert property (sel_mode[0] == fpm_pkg::SEL_MAX_LR2 && s_q.chan_on[1] && s_q.chan_on[2]
		|=> s_q.duty[0] >= $past(speed_local) && s_q.duty[0] >= $past(speed_remote2))
		else $error("faster of local and remote 2 not taken");
	max_all_a: assert property (sel_mode[0] == fpm_pkg::SEL_MAX_ALL && &s_q.chan_on
		|=> s_q.duty[0] >= $past(speed_remote1) && s_q.duty[0] >= $past(speed_local)
		&& s_q.duty[0] >= $past(speed_remote2))
		else $error("fastest channel not taken");

endmodule // fpm_fan_mux

`default_nettype wire

// *** logic/fpm_pkg.sv ***
// register map, reset values, field positions and behaviour codes of the fan drive mux
package fpm_pkg;

	// ========================================
	// register offsets
	localparam logic [7:0] ADDR_DUTY1 = 8'h30;
	localparam logic [7:0] ADDR_DUTY2 = 8'h31;
	localparam logic [7:0] ADDR_DUTY3 = 8'h32;
	localparam logic [7:0] ADDR_CFG1  = 8'h5c;
	localparam logic [7:0] ADDR_CFG2  = 8'h5d;
	localparam logic [7:0] ADDR_CFG3D = 8'h5e;
	localparam logic [7:0] ADDR_ACOUS = 8'h62;
	localparam logic [7:0] ADDR_FLOOR1 = 8'h64;
	localparam logic [7:0] ADDR_FLOOR2 = 8'h65;
	localparam logic [7:0] ADDR_FLOOR3 = 8'h66;
	localparam logic [7:0] ADDR_TMIN1 = 8'h67;
	localparam logic [7:0] ADDR_TMIN2 = 8'h68;
	localparam logic [7:0] ADDR_TMIN3 = 8'h69;
	localparam logic [7:0] ADDR_HYST  = 8'h6d;
	localparam logic [7:0] ADDR_CONF3 = 8'h78;

	// ========================================
	// reset values
	localparam logic [7:0] DUTY_RST  = 8'hff;
	localparam logic [7:0] CFG_RST   = 8'h62;
	localparam logic [7:0] ACOUS_RST = 8'h00;
	localparam logic [7:0] MIN_RST   = 8'h80;
	localparam logic [7:0] TMIN_RST  = 8'h5a;
	localparam logic [7:0] HYST_RST  = 8'h04;
	localparam logic [7:0] CONF3_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// ========================================
	// field positions
	localparam int SEL_HI      = 7;
	localparam int SEL_LO      = 5;
	localparam int POL_BIT     = 4;
	localparam int SHARE_BIT   = 0;
	localparam int HOLD_MIN_LO = 5;

	// ========================================
	// behaviour select codes
	localparam logic [2:0] SEL_REMOTE1 = 3'h0;
	localparam logic [2:0] SEL_LOCAL   = 3'h1;
	localparam logic [2:0] SEL_REMOTE2 = 3'h2;
	localparam logic [2:0] SEL_FULL    = 3'h3;
	localparam logic [2:0] SEL_OFF     = 3'h4;
	localparam logic [2:0] SEL_MAX_LR2 = 3'h5;
	localparam logic [2:0] SEL_MAX_ALL = 3'h6;
	localparam logic [2:0] SEL_MANUAL  = 3'h7;

	// ========================================
	// duty values and waveform counter
	localparam logic [7:0] DUTY_FULL = 8'hff;
	localparam logic [7:0] DUTY_ZERO = 8'h00;
	localparam logic [7:0] PWM_TOP   = 8'hfe;
	localparam int         TACH_EDGES_DEF = 2;

endpackage

// *** verification/fpm_fan_model.sv ***
// fan partner: tach pulses while the drive powers the fan
`timescale 1ns/100ps
`default_nettype none

// ========================================
// fan model
module fpm_fan_model #(
	parameter int HALF = 16
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// fan side
	input  wire logic drive,
	output var  logic tach
);
	logic [7:0] cnt_q;

	// a stopped fan holds its tach level; pulses come only with power
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00;
			tach  <= 1'b0;
		end else if (drive) begin
			if (cnt_q == 8'(HALF - 1)) begin
				cnt_q <= 8'h00;
				tach  <= ~tach;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule // fpm_fan_model

`default_nettype wire

// *** verification/fan_pwm_behaviour_mux_bench.sv ***
// self-checking bench of the fan drive behaviour mux
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

module fan_pwm_behaviour_mux_bench;
	// ========================================
	// signals
	logic       clock = 1'b0;
	logic       nrst = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       alert_req = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] temp_remote1 = 8'h00, temp_local = 8'h00, temp_remote2 = 8'h00;
	logic [7:0] speed_remote1 = 8'h00, speed_local = 8'h00, speed_remote2 = 8'h00;
	logic [7:0] reg_rdata;
	logic       tach_1, tach_2, tach_3;
	logic       fan_drive_1, fan_drive_3, shared_pin_out, shared_pin_oe_n;
	int         mismatches = 0;
	int         comparisons = 0;
	int         highs;
	logic [7:0] mode_exp [7] = '{8'h60, 8'h50, 8'h40, 8'hff, 8'h00, 8'h50, 8'h60};
	logic [7:0] st_temp  [5] = '{8'h56, 8'h55, 8'h5a, 8'h5a, 8'h5a};
	logic [7:0] st_acous [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h20};
	logic [7:0] st_exp   [5] = '{8'h50, 8'h00, 8'h00, 8'h00, 8'h10};

	// ========================================
	// design and fans
	fpm_fan_mux #(.TACH_EDGES(2)) dut (
		.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.temp_remote1(temp_remote1), .temp_local(temp_local), .temp_remote2(temp_remote2),
		.speed_remote1(speed_remote1), .speed_local(speed_local), .speed_remote2(speed_remote2),
		.tach_1(tach_1), .tach_2(tach_2), .tach_3(tach_3), .alert_req(alert_req),
		.fan_drive_1(fan_drive_1), .fan_drive_3(fan_drive_3),
		.shared_pin_out(shared_pin_out), .shared_pin_oe_n(shared_pin_oe_n)
	);
	fpm_fan_model fan1 (.clock(clock), .nrst(nrst), .drive(fan_drive_1), .tach(tach_1));
	fpm_fan_model fan2 (.clock(clock), .nrst(nrst), .drive(shared_pin_out), .tach(tach_2));
	fpm_fan_model fan3 (.clock(clock), .nrst(nrst), .drive(fan_drive_3), .tach(tach_3));

	initial begin
		forever #12.5 clock = ~clock;
	end

	// ========================================
	// register port and pin tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		@(negedge clock);
		`CHK(what, e, reg_rdata)
	endtask

	// settle first: config and duty reach the pin two edges after the write
	task automatic count_high(input int n, output int h);
		h = 0;
		repeat (3) @(posedge clock);
		repeat (255) begin
			@(negedge clock);
			if ((n == 0 ? fan_drive_1 : n == 1 ? shared_pin_out : fan_drive_3) === 1'b1) h++;
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clock);
		mismatches++;
		stop_test();
	end

	// ========================================
	// tests
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		`CHK("drive 1 at reset", 1'b1, fan_drive_1)
		`CHK("shared pin enable", 1'b0, shared_pin_oe_n)
		for (int n = 0; n < 3; n++) begin
			rdc(fpm_pkg::ADDR_DUTY1 + 8'(n), fpm_pkg::DUTY_RST, "duty reset");
			rdc(fpm_pkg::ADDR_CFG1 + 8'(n), fpm_pkg::CFG_RST, "config reset");
		end
		rdc(fpm_pkg::ADDR_ACOUS, fpm_pkg::ACOUS_RST, "acoustic reset");
		rdc(fpm_pkg::ADDR_CONF3, fpm_pkg::CONF3_RST, "config three reset");
		rdc(8'h00, fpm_pkg::RDATA_RST, "unmapped read");
		wr(fpm_pkg::ADDR_DUTY1, 8'h40);
		rdc(fpm_pkg::ADDR_DUTY1, 8'hff, "duty write at full");
		// manual duty and polarity on every output
		for (int n = 0; n < 3; n++) begin
			wr(fpm_pkg::ADDR_CFG1 + 8'(n), {fpm_pkg::SEL_MANUAL, 5'h00});
			wr(fpm_pkg::ADDR_DUTY1 + 8'(n), 8'h80);
			rdc(fpm_pkg::ADDR_DUTY1 + 8'(n), 8'h80, "manual duty");
			count_high(n, highs);
			`CHK("high cycles", 128, highs)
			wr(fpm_pkg::ADDR_CFG1 + 8'(n), {fpm_pkg::SEL_MANUAL, 5'h10});
			count_high(n, highs);
			`CHK("high cycles inverted", 127, highs)
			wr(fpm_pkg::ADDR_DUTY1 + 8'(n), fpm_pkg::DUTY_ZERO);
			count_high(n, highs);
			`CHK("inverted zero duty", 255, highs)
			wr(fpm_pkg::ADDR_CFG1 + 8'(n), fpm_pkg::CFG_RST);
		end
		// behaviour codes 000 to 110 on output 1
		@(posedge clock);
		temp_remote1  <= 8'h60;
		temp_local    <= 8'h60;
		temp_remote2  <= 8'h60;
		speed_remote1 <= 8'h60;
		speed_local   <= 8'h50;
		speed_remote2 <= 8'h40;
		wr(fpm_pkg::ADDR_FLOOR1, 8'h10);
		for (int c = 0; c < 7; c++) begin
			wr(fpm_pkg::ADDR_CFG1, {3'(c), 5'h00});
			repeat (200) @(posedge clock);
			rdc(fpm_pkg::ADDR_DUTY1, mode_exp[c], "duty per behaviour");
		end
		wr(fpm_pkg::ADDR_DUTY1, 8'h22);
		rdc(fpm_pkg::ADDR_DUTY1, 8'h60, "duty write in auto");
		// threshold, hysteresis and hold-min on the local channel
		wr(fpm_pkg::ADDR_CFG1, {fpm_pkg::SEL_LOCAL, 5'h00});
		repeat (200) @(posedge clock);
		for (int i = 0; i < 5; i++) begin
			temp_local <= st_temp[i];
			wr(fpm_pkg::ADDR_ACOUS, st_acous[i]);
			repeat (10) @(posedge clock);
			rdc(fpm_pkg::ADDR_DUTY1, st_exp[i], "threshold step");
		end
		wr(fpm_pkg::ADDR_ACOUS, 8'h00);
		repeat (10) @(posedge clock);
		temp_local <= 8'h5b;
		repeat (4) @(posedge clock);
		rdc(fpm_pkg::ADDR_DUTY1, fpm_pkg::DUTY_FULL, "spin-up duty");
		repeat (200) @(posedge clock);
		rdc(fpm_pkg::ADDR_DUTY1, 8'h50, "after spin-up");
		speed_local <= 8'h05;
		repeat (10) @(posedge clock);
		rdc(fpm_pkg::ADDR_DUTY1, 8'h10, "minimum duty on");
		// shared pin as alert output
		wr(fpm_pkg::ADDR_CONF3, 8'h01);
		alert_req <= 1'b1;
		repeat (3) @(negedge clock);
		`CHK("alert level", 1'b0, shared_pin_out)
		`CHK("alert driven", 1'b0, shared_pin_oe_n)
		@(posedge clock);
		alert_req <= 1'b0;
		repeat (3) @(negedge clock);
		`CHK("alert released", 1'b1, shared_pin_oe_n)
		wr(fpm_pkg::ADDR_CONF3, 8'h00);
		repeat (3) @(negedge clock);
		`CHK("drive 2 back", 1'b1, shared_pin_out)
		`CHK("drive 2 driven", 1'b0, shared_pin_oe_n)
		stop_test();
	end
endmodule // fan_pwm_behaviour_mux_bench

`default_nettype wire
